// File: hw/data_memory_map.sv
/*
  data memory map and stack of the 8-bit core: internal ram decode,
  sfr decode, extended ram window, data pointer, code fetch limits.
  assumes the core presents one access per cycle with synchronous inputs.
*/
// Functional notes
// - code comes from internal flash when the code source pin is high
// - fetches never roll into external code space; out-of-range fetch is flagged
// - a 56 kB part of program memory is rewritable at run time
// - flash data memory is reached only through sfr registers
// - lower 128 ram bytes direct or indirect, upper 128 indirect only
// - sfr space is upper 128 addresses, direct addressing only
// - lowest 32 bytes form four banks of eight working registers
// - bytes 20h-2Fh are bit addressable as bits 00h-7Fh
// - stack pointer resets to 07h, first push at 08h
// - push and call increment pointer first, then write
// - extended stack grows to at most 2048 bytes
// - ram enable bit maps 2 kB extended ram at bottom of data space
// - pointers above 0007FFh always go to external memory
// - internal extended ram hits drive no ports or strobes
// - without extended stack pointer wraps FFh to 00h
// - extended stack continues from FFh to 0100h, 11-bit pointer
// - stack low at sfr 81h, high at B7h bits 2:0
// - stack high byte inaccessible unless extended stack enabled
// - external moves produce strobes over a 16 MB data space
// - page, high, low pointer bytes; increment carries into page
// - core configuration resets to 00h
`timescale 1ns/1ps
`include "memmap_regs.svh"
module data_memory_map
  import memmap_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // code fetch
  input  wire logic        code_source_select_pin,
  input  wire logic [15:0] fetch_addr,
  input  wire logic        fetch_req,
  output logic             code_internal,
  output logic             fetch_fault,
  output logic             code_rw_region,
  // internal data access
  input  wire logic        iram_req,
  input  wire logic        iram_indirect,
  input  wire logic        iram_bit,
  input  wire logic [7:0]  iram_addr,
  input  wire logic        iram_we,
  input  wire logic [7:0]  iram_wdata,
  input  wire logic [1:0]  bank_select,
  input  wire logic        reg_access,
  input  wire logic [2:0]  reg_num,
  output logic      [7:0]  iram_rdata,
  output logic             bit_rdata,
  output logic             sfr_sel,
  output logic      [7:0]  sfr_addr,
  // stack
  input  wire stack_op_t   stack_op,
  output logic      [10:0] stack_addr,
  // data pointer
  input  wire logic        data_pointer_inc,
  // external data move
  input  wire logic        xmove_req,
  input  wire logic        xmove_we,
  input  wire logic [7:0]  xmove_wdata,
  output logic      [7:0]  xmove_rdata,
  output logic             on_chip_extended_ram_hit,
  output logic             ext_bus_req,
  output logic      [23:0] ext_addr,
  output logic      [7:0]  ext_wdata,
  output logic             ext_rd_strobe,
  output logic             ext_wr_strobe,
  output logic             ext_port_drive,
  input  wire logic [7:0]  ext_rdata
);
  logic [7:0]  iram [256];
  logic [7:0]  on_chip_extended_ram [2048];
  logic [7:0]  core_config_reg;
  logic [7:0]  data_pointer_low;
  logic [7:0]  data_pointer_high;
  logic [7:0]  data_pointer_page;
  logic [7:0]  stack_pointer_low;
  logic [7:0]  stack_pointer_high;
  logic        code_mode;

  wire         extended_stack_enable   = core_config_reg[`CFG_EXT_STACK_BIT];
  wire         internal_ext_ram_enable = core_config_reg[`CFG_ON_CHIP_EXTENDED_RAM_EN_BIT];

  function automatic logic [7:0] bit_byte(input logic [6:0] b);
    return `BIT_AREA_BASE + {4'h0, b[6:3]};
  endfunction : bit_byte

  // code space: internal flash when the latched pin is high; no external fetch path exists in this block
  assign code_internal  = code_mode;
  assign fetch_fault    = fetch_req && (fetch_addr > `CODE_LAST_ADDR);
  assign code_rw_region = fetch_addr <= `CODE_RW_LAST_ADDR;

  // internal ram / sfr split
  wire         upper_half   = iram_addr >= `UPPER_RAM_BASE;
  wire         direct_sfr   = iram_req && !iram_indirect && !iram_bit
                              && !reg_access && upper_half;
  wire         bit_sfr      = iram_req && iram_bit && iram_addr[7];
  wire [7:0]   bit_addr_ram = bit_byte(iram_addr[6:0]);
  wire [7:0]   bank_addr    = {3'b000, bank_select, reg_num};
  // indirect reaches upper ram; direct upper addresses go to sfrs
  wire [7:0]   ram_index    = reg_access ? bank_addr
                            : (iram_bit ? bit_addr_ram : iram_addr);
  wire         ram_hit      = iram_req && !direct_sfr && !bit_sfr;
  wire         stack_push   = stack_op == stk_push;
  wire         stack_in_ram = stack_addr[10:8] == 3'b000;

  assign sfr_sel  = direct_sfr || bit_sfr;
  assign sfr_addr = bit_sfr ? {iram_addr[7:3], 3'b000} : iram_addr;

  // sfr decode of the registers this block owns
  wire wr_sfr  = direct_sfr && iram_we;
  wire wr_sp   = wr_sfr && iram_addr == `SFR_STACK_LOW;
  wire wr_sph  = wr_sfr && iram_addr == `SFR_STACK_HIGH;
  wire wr_cfg  = wr_sfr && iram_addr == `SFR_CORE_CONFIG;
  wire wr_dpl  = wr_sfr && iram_addr == `SFR_DATA_POINTER_LOW;
  wire wr_dph  = wr_sfr && iram_addr == `SFR_DATA_POINTER_HIGH;
  wire wr_dpp  = wr_sfr && iram_addr == `SFR_DATA_POINTER_PAGE;

  stack_unit u_stack
  (
    .clock              (clock),
    .rst                (rst),
    .ext_stack_en       (extended_stack_enable),
    .op                 (stack_op),
    .wr_low             (wr_sp),
    .wr_high            (wr_sph),
    .wdata              (iram_wdata),
    .stack_pointer_low  (stack_pointer_low),
    .stack_pointer_high (stack_pointer_high),
    .stack_addr         (stack_addr)
  );

  // sfr read mux; stack high reads zero while hidden
  wire [7:0] sfr_rd =
      (iram_addr == `SFR_STACK_LOW)   ? stack_pointer_low :
      (iram_addr == `SFR_STACK_HIGH)  ? (extended_stack_enable ? stack_pointer_high
                                                               : 8'h00) :
      (iram_addr == `SFR_CORE_CONFIG) ? core_config_reg :
      (iram_addr == `SFR_DATA_POINTER_LOW)    ? data_pointer_low :
      (iram_addr == `SFR_DATA_POINTER_HIGH)   ? data_pointer_high :
      (iram_addr == `SFR_DATA_POINTER_PAGE)   ? data_pointer_page : 8'h00;

  // external data window
  wire [23:0] xaddr     = {data_pointer_page, data_pointer_high, data_pointer_low};
  wire        on_chip_extended_ram_sel  = internal_ext_ram_enable && (xaddr <= `ON_CHIP_EXTENDED_RAM_LAST_ADDR);
  wire        ext_sel   = xmove_req && !on_chip_extended_ram_sel;
  wire        on_chip_extended_ram_req  = xmove_req && on_chip_extended_ram_sel;
  // extended stack bytes above 0ffh live in on-chip extended ram
  wire        stk_on_chip_extended_ram  = (stack_op != stk_none) && !stack_in_ram;
  wire [15:0] data_pointer_next = {data_pointer_high, data_pointer_low} + 16'h0001;
  wire        data_pointer_cy   = data_pointer_inc && ({data_pointer_high, data_pointer_low} == 16'hffff);

  always_ff @(posedge clock)
  begin
    if (rst)
      code_mode <= 1'b0;
    else
      code_mode <= code_source_select_pin; // pin resampled every cycle after release
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      core_config_reg   <= `CORE_CONFIG_RESET;
      data_pointer_low  <= 8'h00;
      data_pointer_high <= 8'h00;
      data_pointer_page <= 8'h00;
    end
    else
    begin
      if (wr_cfg)
        core_config_reg <= iram_wdata;
      if (data_pointer_inc)
      begin
        data_pointer_low  <= data_pointer_next[7:0];
        data_pointer_high <= data_pointer_next[15:8];
        data_pointer_page <= data_pointer_page + {7'h00, data_pointer_cy};
      end
      else
      begin
        if (wr_dpl)
          data_pointer_low <= iram_wdata;
        if (wr_dph)
          data_pointer_high <= iram_wdata;
        if (wr_dpp)
          data_pointer_page <= iram_wdata;
      end
    end
  end

  // memories: no reset, contents undefined at power up
  always_ff @(posedge clock)
  begin
    if (ram_hit && iram_we && !iram_bit)
      iram[ram_index] <= iram_wdata;
    else if (ram_hit && iram_we && iram_bit)
      iram[ram_index][iram_addr[2:0]] <= iram_wdata[0];
    if (stack_push && stack_in_ram)
      iram[stack_addr[7:0]] <= iram_wdata;
    if (stack_push && stk_on_chip_extended_ram)
      on_chip_extended_ram[stack_addr] <= iram_wdata;
    else if (on_chip_extended_ram_req && xmove_we)
      on_chip_extended_ram[xaddr[10:0]] <= xmove_wdata;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      iram_rdata  <= 8'h00;
      bit_rdata   <= 1'b0;
      xmove_rdata <= 8'h00;
    end
    else
    begin
      if (stack_op == stk_pop)
        iram_rdata <= stack_in_ram ? iram[stack_addr[7:0]] : on_chip_extended_ram[stack_addr];
      else if (direct_sfr)
        iram_rdata <= sfr_rd;
      else if (ram_hit)
        iram_rdata <= iram[ram_index];
      if (ram_hit && iram_bit)
        bit_rdata <= iram[ram_index][iram_addr[2:0]];
      if (on_chip_extended_ram_req)
        xmove_rdata <= on_chip_extended_ram[xaddr[10:0]];
      else if (ext_sel)
        xmove_rdata <= ext_rdata;
    end
  end

  // external bus: only driven for misses, so ports stay free on hits
  assign on_chip_extended_ram_hit       = on_chip_extended_ram_req;
  assign ext_bus_req    = ext_sel;
  assign ext_rd_strobe  = ext_sel && !xmove_we;
  assign ext_wr_strobe  = ext_sel && xmove_we;
  assign ext_port_drive = ext_sel;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ext_addr  <= 24'h00_0000;
      ext_wdata <= 8'h00;
    end
    else if (ext_sel)
    begin
      ext_addr  <= xaddr; // full 24-bit window
      ext_wdata <= xmove_wdata;
    end
  end
endmodule : data_memory_map

// File: hw/memmap_regs.svh
/*
  offsets, field positions, reset values and sizes of the data memory map.
  assumes inclusion by name from the design files; definitions only.
*/
`ifndef MEMMAP_REGS_SVH
`define MEMMAP_REGS_SVH
`define SFR_STACK_LOW       8'h81
`define SFR_STACK_HIGH      8'hb7
`define SFR_CORE_CONFIG     8'haf
`define SFR_DATA_POINTER_LOW        8'h82
`define SFR_DATA_POINTER_HIGH       8'h83
`define SFR_DATA_POINTER_PAGE       8'h84
`define STACK_LOW_RESET     8'h07
`define CORE_CONFIG_RESET   8'h00
`define CFG_EXT_STACK_BIT   7
`define CFG_ON_CHIP_EXTENDED_RAM_EN_BIT     0
`define ON_CHIP_EXTENDED_RAM_LAST_ADDR      24'h00_07ff
`define UPPER_RAM_BASE      8'h80
`define BANK_AREA_TOP       8'h1f
`define BIT_AREA_BASE       8'h20
`define CODE_LAST_ADDR      16'hf7ff
`define CODE_RW_LAST_ADDR   16'hdfff
`endif

// File: hw/memmap_pkg.sv
/*
  types shared by the data memory map block.
  assumes memmap_regs.svh supplies the numbers.
*/
package memmap_pkg;
  typedef enum logic [1:0]
  {
    space_direct,
    space_indirect,
    space_bit,
    space_none
  } iram_space_t;
  typedef enum logic [1:0]
  {
    stk_none,
    stk_push,
    stk_pop
  } stack_op_t;
endpackage : memmap_pkg

// File: hw/stack_unit.sv
/*
  stack pointer: low byte, high byte, push/pop address formation.
  assumes the core issues at most one push, pop or sfr write per cycle.
*/
`timescale 1ns/1ps
`include "memmap_regs.svh"
module stack_unit
  import memmap_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // control
  input  wire logic        ext_stack_en,
  input  wire stack_op_t   op,
  // sfr writes
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  input  wire logic [7:0]  wdata,
  // state
  output logic      [7:0]  stack_pointer_low,
  output logic      [7:0]  stack_pointer_high,
  output logic      [10:0] stack_addr
);
  logic [10:0] cur;
  logic [10:0] next_ptr;
  logic [10:0] inc_ptr;
  logic [10:0] dec_ptr;

  // with the extended stack off the top bits read as zero regardless
  assign cur = ext_stack_en ? {stack_pointer_high[2:0], stack_pointer_low}
                            : {3'b000, stack_pointer_low};
  // 8-bit wrap ff->00 or 11-bit carry 00ff->0100
  assign inc_ptr = ext_stack_en ? cur + 11'h001
                                : {3'b000, 8'(stack_pointer_low + 8'h01)};
  assign dec_ptr = ext_stack_en ? cur - 11'h001
                                : {3'b000, 8'(stack_pointer_low - 8'h01)};
  assign next_ptr = (op == stk_push) ? inc_ptr : (op == stk_pop) ? dec_ptr : cur;
  // push writes at the incremented pointer, pop reads at the current one
  assign stack_addr = (op == stk_push) ? inc_ptr : cur;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      stack_pointer_low  <= `STACK_LOW_RESET;
      stack_pointer_high <= 8'h00;
    end
    else if (op != stk_none)
    begin
      stack_pointer_low  <= next_ptr[7:0];
      if (ext_stack_en)
        stack_pointer_high <= {5'b00000, next_ptr[10:8]};
    end
    else
    begin
      if (wr_low)
        stack_pointer_low <= wdata;
      if (wr_high && ext_stack_en)
        stack_pointer_high <= {5'b00000, wdata[2:0]};
    end
  end
endmodule : stack_unit

// File: test/ext_mem_model.sv
/*
  external data memory on the far side of the block's bus.
  assumes read data is sampled while the read strobe is high.
*/
`timescale 1ns/1ps
module ext_mem_model
(
  // external bus
  input  wire logic       ext_rd_strobe,
  output logic      [7:0] ext_rdata
);
  // an idle bus shows another byte, so a read taken outside the strobe never matches
  assign ext_rdata = ext_rd_strobe ? 8'h5a : 8'ha5;
endmodule : ext_mem_model

// File: test/data_memory_map_sva.sv
/*
  port checks of data_memory_map.
  assumes sync active-high rst; bound into every instance.
*/
`timescale 1ns/1ps
module data_memory_map_sva
  import memmap_pkg::*;
(
  // clock, reset, fetch
  input wire logic        clock, rst, fetch_req, fetch_fault, code_rw_region,
  input wire logic [15:0] fetch_addr,
  // internal data
  input wire logic        iram_req, iram_indirect, iram_bit, sfr_sel, reg_access,
  input wire logic [7:0]  iram_addr, sfr_addr,
  // stack
  input wire stack_op_t   stack_op,
  input wire logic [10:0] stack_addr,
  // external move
  input wire logic        xmove_req, xmove_we, on_chip_extended_ram_hit, ext_bus_req,
  input wire logic        ext_rd_strobe, ext_wr_strobe, ext_port_drive
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  property p_fetch; fetch_req |-> fetch_fault == (fetch_addr > 16'hf7ff); endproperty
  a_fetch: assert property (p_fetch) else $error("fetch fault wrong");
  property p_rw; fetch_req |-> code_rw_region == (fetch_addr <= 16'hdfff); endproperty
  a_rw: assert property (p_rw) else $error("rewritable flag wrong");
  // non-bit, non-register accesses select sfrs only for direct upper addresses
  property p_sfr;
    iram_req && !iram_bit && !reg_access |-> sfr_sel == (!iram_indirect && iram_addr[7]);
  endproperty
  a_sfr: assert property (p_sfr) else $error("sfr select wrong");
  property p_bit;
    iram_req && iram_bit |-> sfr_sel == iram_addr[7]
      && (!iram_addr[7] || sfr_addr == {iram_addr[7:3], 3'b000});
  endproperty
  a_bit: assert property (p_bit) else $error("bit decode wrong");
  property p_first; $past(rst) && stack_op == stk_push |-> stack_addr == 11'h008; endproperty
  a_first: assert property (p_first) else $error("first push address wrong");
  property p_step;
    stack_op == stk_push && $past(stack_op) == stk_push && !$past(rst)
      && $past(stack_addr[7:0]) != 8'hff |-> stack_addr == $past(stack_addr) + 11'h001;
  endproperty
  a_step: assert property (p_step) else $error("push did not pre-increment");
  property p_quiet;
    on_chip_extended_ram_hit |-> !ext_bus_req && !ext_rd_strobe && !ext_wr_strobe && !ext_port_drive;
  endproperty
  a_quiet: assert property (p_quiet) else $error("bus driven on internal hit");
  property p_miss;
    xmove_req && !on_chip_extended_ram_hit |-> ext_bus_req && ext_rd_strobe == !xmove_we && ext_wr_strobe == xmove_we;
  endproperty
  a_miss: assert property (p_miss) else $error("miss strobes wrong");
endmodule : data_memory_map_sva
bind data_memory_map data_memory_map_sva checker_i (.*);

// File: test/tb.sv
/*
  bench for data_memory_map: drives core-side accesses and checks answers.
  assumes ext_mem_model on the external bus and the checker bound in.
*/
`timescale 1ns/1ps
module tb
  import memmap_pkg::*;
;
  logic        clock, rst, iram_req, iram_indirect, iram_bit, iram_we, xmove_req, xmove_we;
  logic        code_source_select_pin = 1'b1, fetch_req = 1'b0, reg_access = 1'b0;
  logic        data_pointer_inc = 1'b0, hit;
  logic        code_internal, fetch_fault, code_rw_region, bit_rdata, sfr_sel, on_chip_extended_ram_hit;
  logic        ext_bus_req, ext_rd_strobe, ext_wr_strobe, ext_port_drive;
  logic [1:0]  bank_select = 2'h0;
  logic [2:0]  reg_num = 3'h0;
  logic [7:0]  iram_addr, iram_wdata, xmove_wdata, iram_rdata, sfr_addr, xmove_rdata;
  logic [7:0]  ext_wdata, ext_rdata;
  logic [10:0] stack_addr, sa;
  logic [15:0] fetch_addr = 16'h0000;
  logic [23:0] ext_addr;
  stack_op_t   stack_op;
  int          failures = 0;
  int          checked = 0;
  data_memory_map uut (.*);
  ext_mem_model far_end (.*);
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // f = {xmove_req, iram_req, iram_indirect, iram_bit, write}
  task cyc(input logic [4:0] f, input logic [7:0] a, input logic [7:0] d, input stack_op_t so);
    {xmove_req, iram_req, iram_indirect, iram_bit, iram_we} = f;
    xmove_we = f[0];
    iram_addr = a;
    iram_wdata = d;
    xmove_wdata = d;
    stack_op = so;
    #5 sa = stack_addr;
    hit = on_chip_extended_ram_hit;
    @(posedge clock);
    #1;
  endtask : cyc
  task wr(input logic [7:0] a, input logic [7:0] d);
    cyc(5'b01001, a, d, stk_none);
  endtask : wr
  task rd(input logic [4:0] f, input logic [7:0] a, input logic [7:0] e);
    cyc(f, a, 8'h00, stk_none);
    chk("iram_rdata", 24'(e), 24'(iram_rdata));
  endtask : rd
  task sp(input stack_op_t so, input logic [7:0] d, input logic [10:0] e);
    cyc(5'b00000, 8'h00, d, so);
    chk("stack_addr", 24'(e), 24'(sa));
  endtask : sp
  task xm(input logic we, input logic [7:0] d, input logic e);
    cyc({4'b1000, we}, 8'h00, d, stk_none);
    chk("on_chip_extended_ram_hit", 24'(e), 24'(hit));
  endtask : xm
  task finish_test;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  initial
  begin
    rst = 1'b1;
    repeat (20) cyc(5'b00000, 8'h00, 8'h00, stk_none);
    rst = 1'b0;
    sp(stk_push, 8'h3c, 11'h008);
    sp(stk_push, 8'h3d, 11'h009);
    sp(stk_pop, 8'h00, 11'h009);
    chk("iram_rdata", 24'h00_003d, 24'(iram_rdata));
    rd(5'b01000, 8'h81, 8'h08);
    rd(5'b01000, 8'haf, 8'h00);
    wr(8'hb7, 8'h05);
    rd(5'b01000, 8'hb7, 8'h00);
    wr(8'haf, 8'h80);
    wr(8'hb7, 8'h05);
    rd(5'b01000, 8'hb7, 8'h05);
    wr(8'hb7, 8'h00);
    wr(8'h81, 8'hff);
    sp(stk_push, 8'h11, 11'h100);
    wr(8'hb7, 8'h05);
    wr(8'haf, 8'h00);
    rd(5'b01000, 8'hb7, 8'h00);
    wr(8'h81, 8'hff);
    sp(stk_push, 8'h22, 11'h000);
    bank_select = 2'h2;
    reg_num = 3'h3;
    reg_access = 1'b1;
    wr(8'h00, 8'h6e);
    reg_access = 1'b0;
    rd(5'b01000, 8'h13, 8'h6e);
    wr(8'h21, 8'h04);
    for (int i = 8; i < 16; i++)
    begin
      cyc(5'b01010, 8'(i), 8'h00, stk_none);
      chk("bit_rdata", 24'(i == 10), 24'(bit_rdata));
    end
    cyc(5'b01010, 8'he0, 8'h00, stk_none);
    cyc(5'b01101, 8'h90, 8'h77, stk_none);
    wr(8'h90, 8'h55);
    rd(5'b01100, 8'h90, 8'h77);
    wr(8'h40, 8'h12);
    rd(5'b01100, 8'h40, 8'h12);
    wr(8'h84, 8'h00);
    wr(8'h83, 8'h07);
    wr(8'h82, 8'hff);
    wr(8'haf, 8'h01);
    xm(1'b1, 8'h99, 1'b1);
    xm(1'b0, 8'h00, 1'b1);
    chk("xmove_rdata", 24'h00_0099, 24'(xmove_rdata));
    data_pointer_inc = 1'b1;
    cyc(5'b00000, 8'h00, 8'h00, stk_none);
    data_pointer_inc = 1'b0;
    xm(1'b0, 8'h00, 1'b0);
    chk("xmove_rdata", 24'h00_005a, 24'(xmove_rdata));
    chk("ext_addr", 24'h00_0800, ext_addr);
    wr(8'h83, 8'hff);
    wr(8'h82, 8'hff);
    data_pointer_inc = 1'b1;
    cyc(5'b00000, 8'h00, 8'h00, stk_none);
    data_pointer_inc = 1'b0;
    xm(1'b1, 8'h42, 1'b0);
    chk("ext_addr", 24'h01_0000, ext_addr);
    chk("ext_wdata", 24'h00_0042, 24'(ext_wdata));
    wr(8'haf, 8'h00);
    wr(8'h84, 8'h00);
    wr(8'h83, 8'h00);
    xm(1'b0, 8'h00, 1'b0);
    fetch_req = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      fetch_addr = (i == 0) ? 16'hdfff : ((i == 1) ? 16'hf7ff : 16'hf800);
      cyc(5'b00000, 8'h00, 8'h00, stk_none);
      chk("code_rw_region", 24'(i == 0), 24'(code_rw_region));
      chk("fetch_fault", 24'(i == 2), 24'(fetch_fault));
    end
    chk("code_internal", 24'h00_0001, 24'(code_internal));
    finish_test;
  end
endmodule : tb
